// [src/mpc_defs.vh]
// Constants of the memory protection control register block
`ifndef MPC_DEFS_VH
`define MPC_DEFS_VH
// Register indices; the bus byte address of each word is four times its index
`define MPC_IDX_CTL 8'h00
`define MPC_IDX_STAT 8'h02
`define MPC_IDX_SEG 8'h04
`define MPC_OFF_CTL 8'h00
`define MPC_OFF_STAT 8'h08
`define MPC_OFF_SEG 8'h10
`define MPC_KEY_READ 8'h96
`define MPC_KEY_GOOD 8'hA5
`define MPC_CTL_ENA_BIT 0
`define MPC_CTL_RSV1_BIT 1
`define MPC_CTL_RSV4_BIT 4
`define MPC_FLAG_W 4
`define MPC_BND_W 5
`define MPC_UBND_LSB 8
`define MPC_LBND_LSB 0
`endif

// [src/mpc_fault_flag.v]
// One sticky violation flag with software and vector-read clears
`timescale 1ns/1ps
module mpc_fault_flag (
	input wire hclk,
	input wire hresetn,
	input wire set_in,
	input wire wr_clr,
	input wire vec_clr,
	output reg flag_reg
);
	// Set wins over either clear so no event is lost
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_reg <= 1'b0;
		end else if (set_in) begin
			flag_reg <= 1'b1;
		end else if (wr_clr || vec_clr) begin
			flag_reg <= 1'b0;
		end
	end
endmodule // mpc_fault_flag

// [src/mpc_regs.v]
// Protection unit control, status and boundary registers on AHB-Lite
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "mpc_defs.vh"
module mpc_regs (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [3:0] viol_detect,
	input wire [3:0] fault_action_select,
	input wire reset_cause_vector_rd,
	output wire protection_on_bit,
	output wire [4:0] upper_boundary_field,
	output wire [4:0] lower_boundary_field,
	output reg soft_system_reset
);
	////////////////////////////////////////////////////////////////////////////
	// Address phase capture
	// Every transfer takes an address phase and a data phase of one cycle each.
	// A write is decoded from flops filled in the address phase and hwdata of the
	// data phase; registers change at the edge that ends the data phase.
	// A read picks its word at the address phase edge, so hrdata stands for the
	// whole data phase and holds until the next read address phase.
	// Limitation: a read placed right behind a write to the same word returns the
	// value from before that write, since the write lands on the same edge that picks the read word.
	// Soft reset is a registered pulse of one cycle, one edge after its cause.
	// Permission starts revoked after reset; only the key byte reopens it.
	reg wr_pend_reg;
	reg [7:0] addr_reg;
	reg [2:0] size_reg;
	reg [1:0] lane_reg;
	reg [31:0] rdata_reg;
	reg unlock_reg;
	reg ena_reg;
	reg rsv1_reg;
	reg rsv4_reg;
	reg [4:0] ubnd_reg;
	reg [4:0] lbnd_reg;
	wire [3:0] flags;
	wire addr_phase;

	assign addr_phase = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;
	assign protection_on_bit = ena_reg;
	assign upper_boundary_field = ubnd_reg;
	assign lower_boundary_field = lbnd_reg;

	// Address phase is held in flops for the data phase that follows
	reg wr_pend_next;
	reg [7:0] addr_next;
	reg [2:0] size_next;
	reg [1:0] lane_next;

	// Byte lane comes from haddr[1:0]; the word address drops it
	always @* begin
		wr_pend_next = addr_phase && hwrite;
		addr_next = addr_reg;
		size_next = size_reg;
		lane_next = lane_reg;
		if (addr_phase) begin
			addr_next = {haddr[7:2], 2'b00};
			size_next = hsize;
			lane_next = haddr[1:0];
		end
	end

	// Address phase flops
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			size_reg <= 3'h0;
			lane_reg <= 2'h0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			addr_reg <= addr_next;
			size_reg <= size_next;
			lane_reg <= lane_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write decode
	wire is_word;
	wire wr_lo;
	wire wr_hi;
	wire [7:0] lo_byte;
	wire [7:0] hi_byte;
	wire wr_ctl;
	wire wr_stat;
	wire wr_seg;
	wire wr_other;
	wire key_ok;

	// A byte access picks its lane; halfword or word covers both low bytes
	assign is_word = (size_reg != 3'h0);
	assign wr_lo = wr_pend_reg && (is_word || lane_reg == 2'h0);
	assign wr_hi = wr_pend_reg && (is_word || lane_reg == 2'h1);
	assign lo_byte = hwdata[7:0];
	assign hi_byte = hwdata[15:8];
	assign wr_ctl = addr_reg == `MPC_OFF_CTL;
	assign wr_stat = addr_reg == `MPC_OFF_STAT;
	assign wr_seg = addr_reg == `MPC_OFF_SEG;
	assign wr_other = wr_stat || wr_seg;
	assign key_ok = hi_byte == `MPC_KEY_GOOD;

	////////////////////////////////////////////////////////////////////////////
	// Next-value logic, one combinational process per register group
	reg unlock_next;
	reg ena_next;
	reg rsv1_next;
	reg rsv4_next;
	reg [4:0] ubnd_next;
	reg [4:0] lbnd_next;
	wire ctl_lo_ok;
	wire seg_wr_ok;

	// Word write with good key may set enable in the same transfer
	assign ctl_lo_ok = wr_ctl && wr_lo && (is_word ? key_ok : unlock_reg);
	// Boundary bytes land only while permission stands
	assign seg_wr_ok = unlock_reg && wr_seg;

	// Permission: key byte writes always land, even while locked
	always @* begin
		unlock_next = unlock_reg;
		if (wr_ctl && wr_hi) begin
			unlock_next = key_ok;
		end
	end

	// Low control byte; reserved bits 4 and 1 are kept as written
	always @* begin
		ena_next = ena_reg;
		rsv1_next = rsv1_reg;
		rsv4_next = rsv4_reg;
		if (ctl_lo_ok) begin
			ena_next = lo_byte[`MPC_CTL_ENA_BIT];
			rsv1_next = lo_byte[`MPC_CTL_RSV1_BIT]; // Software keeps zero here
			rsv4_next = lo_byte[`MPC_CTL_RSV4_BIT];
		end
	end

	// Boundary word, byte-wise; the upper field sits in the second lane
	always @* begin
		ubnd_next = ubnd_reg;
		lbnd_next = lbnd_reg;
		if (seg_wr_ok && wr_hi) begin
			ubnd_next = hi_byte[4:0];
		end
		if (seg_wr_ok && wr_lo) begin
			lbnd_next = lo_byte[4:0];
		end
	end

	// Control state flops
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unlock_reg <= 1'b0;
			ena_reg <= 1'b0;
			rsv1_reg <= 1'b0;
			rsv4_reg <= 1'b0;
		end else begin
			unlock_reg <= unlock_next;
			ena_reg <= ena_next;
			rsv1_reg <= rsv1_next;
			rsv4_reg <= rsv4_next;
		end
	end

	// Boundary flops; zero after reset leaves only segment 3 active
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ubnd_reg <= 5'h00;
			lbnd_reg <= 5'h00;
		end else begin
			ubnd_reg <= ubnd_next;
			lbnd_reg <= lbnd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Violation flags; priority order info > seg3 > seg2 > seg1
	wire [3:0] wclr;
	wire [3:0] vclr;
	wire stat_wr_ok;
	reg [3:0] hipend;
	// Status clears need permission; a locked write pulses soft reset instead
	assign stat_wr_ok = unlock_reg && wr_lo && wr_stat;
	assign wclr = {4{stat_wr_ok}} & ~hwdata[3:0];
	// Only the highest pending flag clears on a vector read
	always @* begin
		if (flags[3]) begin
			hipend = 4'h8;
		end else if (flags[2]) begin
			hipend = 4'h4;
		end else if (flags[1]) begin
			hipend = 4'h2;
		end else if (flags[0]) begin
			hipend = 4'h1;
		end else begin
			hipend = 4'h0;
		end
	end
	assign vclr = {4{reset_cause_vector_rd}} & hipend;

	genvar gi;
	generate
		for (gi = 0; gi < `MPC_FLAG_W; gi = gi + 1) begin : g_flag
			mpc_fault_flag u_flag (
				.hclk(hclk),
				.hresetn(hresetn),
				.set_in(viol_detect[gi]),
				.wr_clr(wclr[gi]),
				.vec_clr(vclr[gi]),
				.flag_reg(flags[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Soft reset pulse: bad word key, locked write, or selected violation
	wire bad_word_key;
	wire locked_wr;
	wire fault_reset;
	reg soft_reset_next;
	assign bad_word_key = wr_ctl && wr_pend_reg && is_word && !key_ok;
	assign locked_wr = wr_other && wr_pend_reg && !unlock_reg;
	assign fault_reset = |(viol_detect & fault_action_select);

	// Causes in one cycle merge into a single pulse
	always @* begin
		soft_reset_next = 1'b0;
		if (bad_word_key || locked_wr || fault_reset) begin
			soft_reset_next = 1'b1;
		end
	end

	// Registered so the pulse is glitch free for the reset logic
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			soft_system_reset <= 1'b0;
		end else begin
			soft_system_reset <= soft_reset_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data registered at the address phase, ready one edge later
	wire [15:0] ctl_word;
	wire [15:0] stat_word;
	wire [15:0] seg_word;
	wire [7:0] rd_addr;
	reg [31:0] rdata_next;
	assign ctl_word = {`MPC_KEY_READ, 3'b000, rsv4_reg, 2'b00, rsv1_reg, ena_reg};
	assign stat_word = {12'h000, flags};
	assign seg_word = {3'b000, ubnd_reg, 3'b000, lbnd_reg};
	assign rd_addr = {haddr[7:2], 2'b00};

	// Read mux; unmapped words read zero, idle cycles keep the last word
	always @* begin
		rdata_next = rdata_reg;
		if (addr_phase && !hwrite) begin
			case (rd_addr)
				`MPC_OFF_CTL: begin
					rdata_next = {16'h0000, ctl_word};
				end
				`MPC_OFF_STAT: begin
					rdata_next = {16'h0000, stat_word};
				end
				`MPC_OFF_SEG: begin
					rdata_next = {16'h0000, seg_word};
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	// Read data flop
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
endmodule // mpc_regs

// [bench/mpc_regs_checker.sv]
// Port-level assertions for the protection register block
`timescale 1ns/1ps
`include "mpc_defs.vh"
module mpc_regs_checker (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire [3:0] viol_detect,
	input wire [3:0] fault_action_select,
	input wire protection_on_bit,
	input wire [4:0] upper_boundary_field,
	input wire [4:0] lower_boundary_field,
	input wire soft_system_reset
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Address phase qualifiers; wc is any write aimed at the control word
	wire ap = hsel & hready & htrans[1];
	wire wc = ap & hwrite & ({haddr[7:2], 2'h0} == `MPC_OFF_CTL);
	wire wcw = wc & (haddr[1:0] == 2'h0) & (hsize != 3'h0);
	wire wch = wc & (haddr[1:0] == 2'h1) & (hsize == 3'h0);
	// Reads see the data phase one edge after the address phase
	a_key_reads: assert property (ap && !hwrite && haddr == `MPC_OFF_CTL |=> hrdata[15:8] == `MPC_KEY_READ
		&& hrdata[7:5] == 3'h0 && hrdata[3:2] == 2'h0) else $error("control read wrong");
	a_stat_zero: assert property (ap && !hwrite && haddr == `MPC_OFF_STAT |=> hrdata[15:4] == 12'h0)
		else $error("status reserved bits set");
	// Soft reset comes the cycle after the write data phase
	a_bad_key: assert property (wcw ##1 hwdata[15:8] != `MPC_KEY_GOOD |=> soft_system_reset)
		else $error("wrong key word write kept quiet");
	a_good_key: assert property (wcw ##1 hwdata[15:8] == `MPC_KEY_GOOD |=> protection_on_bit == $past(hwdata[0]))
		else $error("enable not taken");
	a_byte_key: assert property (wch ##1 (viol_detect & fault_action_select) == 4'h0 |=> !soft_system_reset)
		else $error("byte key write reset");
	a_fault_reset: assert property ((viol_detect & fault_action_select) != 4'h0 |=> soft_system_reset)
		else $error("fault action without reset");
	a_reset_vals: assert property ($rose(hresetn) |-> !protection_on_bit && upper_boundary_field == 5'h0
		&& lower_boundary_field == 5'h0) else $error("reset values wrong");
	// Boundaries may only move two edges after a write address phase
	a_bnd_hold: assert property (!(ap && hwrite) |-> ##2 $stable(upper_boundary_field) && $stable(lower_boundary_field))
		else $error("boundary moved without write");
endmodule // mpc_regs_checker
//////////////////////////////////////////////////
bind mpc_regs mpc_regs_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.viol_detect(viol_detect), .fault_action_select(fault_action_select), .protection_on_bit(protection_on_bit),
	.upper_boundary_field(upper_boundary_field), .lower_boundary_field(lower_boundary_field),
	.soft_system_reset(soft_system_reset));

// [bench/tb_top.sv]
// Bench for the protection register block over AHB-Lite
`timescale 1ns/1ps
`include "mpc_defs.vh"
module tb_top;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [7:0] haddr = 8'h00;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [2:0] hsize = 3'h0;
	reg [31:0] hwdata = 32'h0;
	reg [3:0] viol = 4'h0;
	reg [3:0] fas = 4'h0;
	reg vec_rd = 1'b0;
	reg [31:0] rdat;
	wire [31:0] hrdata;
	wire hready, hresp, prot_on, sreset;
	wire [4:0] ubnd, lbnd;
	integer err_count = 0;
	integer compares = 0;
	integer cycles = 0;
	always #2 hclk = ~hclk;
	mpc_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .viol_detect(viol), .fault_action_select(fas), .reset_cause_vector_rd(vec_rd),
		.protection_on_bit(prot_on), .upper_boundary_field(ubnd), .lower_boundary_field(lbnd),
		.soft_system_reset(sreset));
	task tally_and_finish;
		begin
			if (err_count == 0 && compares > 0) begin
				$display("[ PASS ]");
			end else begin
				$display("[ FAIL ]");
			end
			$finish;
		end
	endtask
	// A hang ends the run as a failure
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count = err_count + 1;
			tally_and_finish;
		end
	end
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("Error %0t: got %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// One single transfer; no wait count is assumed, only hready is trusted
	task xfer(input [7:0] a, input w, input [2:0] s, input [31:0] d);
		begin
			hsel <= 1'b1;
			haddr <= a;
			hwrite <= w;
			hsize <= s;
			htrans <= 2'h2;
			@(posedge hclk);
			while (hready !== 1'b1) @(posedge hclk);
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge hclk);
			while (hready !== 1'b1) @(posedge hclk);
			rdat = hrdata;
		end
	endtask
	// Soft reset stands in the cycle after the data phase
	task wr(input [7:0] a, input [2:0] s, input [31:0] d, input e);
		begin
			xfer(a, 1'b1, s, d);
			@(posedge hclk);
			chk({31'h0, sreset}, {31'h0, e});
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			xfer(a, 1'b0, 3'h2, 32'h0);
			chk(rdat, e);
		end
	endtask
	// One-cycle event on the violation and vector-read inputs
	task pulse(input [3:0] v, input [3:0] f, input c, input e);
		begin
			@(posedge hclk);
			viol <= v;
			fas <= f;
			vec_rd <= c;
			@(posedge hclk);
			viol <= 4'h0;
			fas <= 4'h0;
			vec_rd <= 1'b0;
			@(posedge hclk);
			chk({31'h0, sreset}, {31'h0, e});
		end
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`MPC_OFF_CTL, 32'h9600);
		rd(`MPC_OFF_STAT, 32'h0);
		rd(8'h0C, 32'h0);
		wr(`MPC_OFF_STAT, 3'h2, 32'h0, 1'b1);
		wr(`MPC_OFF_CTL, 3'h2, 32'hA501, 1'b0);
		chk(prot_on, 1'b1);
		rd(`MPC_OFF_CTL, 32'h9601);
		wr(`MPC_OFF_SEG, 3'h2, 32'hFFFF, 1'b0);
		rd(`MPC_OFF_SEG, 32'h1F1F);
		chk(ubnd, 5'h1F);
		pulse(4'hF, 4'h0, 1'b0, 1'b0);
		rd(`MPC_OFF_STAT, 32'hF);
		wr(`MPC_OFF_STAT, 3'h2, 32'hA, 1'b0);
		rd(`MPC_OFF_STAT, 32'hA);
		pulse(4'h0, 4'h0, 1'b1, 1'b0);
		rd(`MPC_OFF_STAT, 32'h2);
		pulse(4'h2, 4'h2, 1'b0, 1'b1);
		wr(`MPC_OFF_CTL + 8'h01, 3'h0, 32'h3300, 1'b0);
		wr(`MPC_OFF_SEG, 3'h2, 32'h0, 1'b1);
		rd(`MPC_OFF_SEG, 32'h1F1F);
		wr(`MPC_OFF_CTL, 3'h0, 32'h0, 1'b0);
		rd(`MPC_OFF_CTL, 32'h9601);
		wr(`MPC_OFF_CTL + 8'h01, 3'h0, 32'hA500, 1'b0);
		wr(`MPC_OFF_CTL, 3'h0, 32'h0, 1'b0);
		chk(prot_on, 1'b0);
		wr(`MPC_OFF_CTL, 3'h2, 32'h1234, 1'b1);
		tally_and_finish;
	end
endmodule // tb_top
